// ### core/ccr_pkg.sv
// constants and types for the charger control register bank
package ccr_pkg;

	// ------------------------------------------------------------
	// register map
	// ------------------------------------------------------------
	localparam logic [7:0] OFS_PWR_PATH = 8'h21;
	localparam logic [7:0] OFS_DPLUS_TMR = 8'h22;
	localparam logic [7:0] OFS_ICL = 8'h23;
	localparam logic [7:0] RST_PWR_PATH = 8'h40;
	localparam logic [7:0] RST_DPLUS_TMR = 8'h00;
	localparam logic [7:0] RST_ICL = 8'h2F;
	localparam logic [7:0] UNMAPPED_READ = 8'h00;
	// arbitrary bus address, no maker meaning
	localparam logic [6:0] DEF_BUS_ADDR = 7'h2A;

	// ------------------------------------------------------------
	// field layouts
	// ------------------------------------------------------------
	typedef struct packed {
		logic rsvd;
		logic pin_control_source_select;
		logic powerpath_pin_level;
		logic input_voltage_reg_disable;
		logic [3:0] input_voltage_reg_level;
	} ccr_pwr_path_t;

	typedef struct packed {
		logic release_dplus_source;
		logic dplus_source_state;
		logic [2:0] fast_charge_timeout;
		logic [1:0] precharge_timeout;
		logic charge_timer_hold;
	} ccr_dplus_tmr_t;

	typedef struct packed {
		logic [4:0] input_current_limit;
		logic [2:0] rsvd;
	} ccr_icl_t;

	// ------------------------------------------------------------
	// decode constants
	// ------------------------------------------------------------
	localparam logic [13:0] MV_LOW_BASE = 14'h0FA0;
	localparam logic [13:0] MV_LOW_STEP = 14'h00FA;
	localparam logic [13:0] MV_HIGH_BASE = 14'h1B58;
	localparam logic [13:0] MV_HIGH_STEP = 14'h01F4;
	localparam logic [4:0] FC_BASE_HRS = 5'h04;
	localparam logic [4:0] FC_STEP_HRS = 5'h02;
	localparam logic [2:0] FC_LAST_CODE = 3'h6;
	localparam logic [5:0] PRC_BASE_MIN = 6'h1E;
	localparam logic [5:0] PRC_STEP_MIN = 6'h0F;
	localparam logic [1:0] PRC_LAST_CODE = 2'h2;
	localparam logic [11:0] ICL_MA_100 = 12'h064;
	localparam logic [11:0] ICL_MA_150 = 12'h096;
	localparam logic [11:0] ICL_MA_500 = 12'h1F4;
	localparam logic [11:0] ICL_STEP_MA = 12'h064;
	localparam logic [4:0] ICL_CODE_150 = 5'h02;
	localparam logic [4:0] ICL_CODE_500 = 5'h04;
	localparam logic [4:0] ICL_CODE_STEP = 5'h06;
	localparam logic [4:0] ICL_CODE_OFF = 5'h1F;

	// ------------------------------------------------------------
	// serial slave states
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_ADDR = 3'b001,
		ST_REG = 3'b010,
		ST_WR = 3'b011,
		ST_RD = 3'b100,
		ST_ACK = 3'b101,
		ST_MACK = 3'b110
	} ccr_state_t;

	localparam logic [2:0] BIT_LAST = 3'h7;

endpackage

// ### core/ccr_regs.sv
// charger control registers 0x21..0x23 behind a serial two-wire slave
//
// Operation
// - source select cleared gives the power-path pin to software, set gives it to hardware, reset set.
// - the pin level bit drives the power-path pin only while software owns it.
// - under software control level zero pulls the pin up to the system rail, one pulls it to ground.
// - voltage level codes 0000 to 0011 select 4.0, 4.25, 4.5 and 4.75 volts.
// - voltage level codes 0100 to 0111 select 7.0, 7.5, 8.0 and 8.5 volts.
// - writing one to the release bit frees the 0.6V D+ source, writing zero does nothing.
// - the D+ state bit reads zero while the source pulls, one once released, and ignores writes.
// - the fast charge timeout codes 000 to 110 select 4 to 16 hours in 2 hour steps.
// - the pre-charge timeout codes 00, 01, 10 select 30, 45 and 60 minutes.
// - the timer hold bit lets the safety timers run when clear and freezes them when set.
// - current limit codes 0000X, 0001X, 0010X give 100, 150, 500mA, 00110 600mA, 00111 700mA.
// - from 00110 the limit rises 100mA per code up to 3A at 11110, and 11111 turns it off.
`timescale 1ns/1ps

module ccr_regs #(
	parameter logic [6:0] BUS_ADDR = ccr_pkg::DEF_BUS_ADDR
) (
	input wire logic i_sys_clk,
	input wire logic i_rst_n,
	input wire logic i_scl,
	input wire logic i_sda,
	output logic o_sda_out,
	output logic o_sda_oe_n,
	input wire logic i_hw_powerpath_pull_low,
	input wire logic i_dplus_source_arm,
	output logic o_powerpath_pull_up,
	output logic o_powerpath_pull_down,
	output logic o_min_input_voltage_regulation_en,
	output logic [13:0] o_min_input_voltage_mv,
	output logic o_dplus_source_on,
	output logic [4:0] o_fast_charge_hours,
	output logic [5:0] o_precharge_minutes,
	output logic o_charge_timer_hold,
	output logic o_average_input_current_regulation_en,
	output logic [11:0] o_input_current_limit_ma
);

	// ------------------------------------------------------------
	// decode functions
	// ------------------------------------------------------------
	// codes 1xxx alias onto 0xxx
	function automatic logic [13:0] volt_mv(input logic [3:0] lvl);
		logic [13:0] idx;
		idx = {12'h000, lvl[1:0]};
		if (lvl[2]) begin
			volt_mv = 14'(ccr_pkg::MV_HIGH_BASE + idx * ccr_pkg::MV_HIGH_STEP);
		end else begin
			volt_mv = 14'(ccr_pkg::MV_LOW_BASE + idx * ccr_pkg::MV_LOW_STEP);
		end
	endfunction

	function automatic logic [11:0] icl_ma(input logic [4:0] code);
		if (code < ccr_pkg::ICL_CODE_150) begin
			icl_ma = ccr_pkg::ICL_MA_100;
		end else if (code < ccr_pkg::ICL_CODE_500) begin
			icl_ma = ccr_pkg::ICL_MA_150;
		end else if (code < ccr_pkg::ICL_CODE_STEP) begin
			icl_ma = ccr_pkg::ICL_MA_500;
		end else if (code == ccr_pkg::ICL_CODE_OFF) begin
			icl_ma = 12'h000;
		end else begin
			icl_ma = 12'({7'h00, code} * ccr_pkg::ICL_STEP_MA);
		end
	endfunction

	// ------------------------------------------------------------
	// pin synchronisers
	// ------------------------------------------------------------
	logic scl_meta_ff, scl_sync_ff, scl_prev_ff;
	logic sda_meta_ff, sda_sync_ff, sda_prev_ff;

	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			scl_meta_ff <= 1'b1;
			scl_sync_ff <= 1'b1;
			scl_prev_ff <= 1'b1;
			sda_meta_ff <= 1'b1;
			sda_sync_ff <= 1'b1;
			sda_prev_ff <= 1'b1;
		end else begin
			scl_meta_ff <= i_scl;
			scl_sync_ff <= scl_meta_ff;
			scl_prev_ff <= scl_sync_ff;
			sda_meta_ff <= i_sda;
			sda_sync_ff <= sda_meta_ff;
			sda_prev_ff <= sda_sync_ff;
		end
	end

	logic scl_rise, scl_fall, bus_start, bus_stop;
	assign scl_rise = scl_sync_ff & ~scl_prev_ff;
	assign scl_fall = ~scl_sync_ff & scl_prev_ff;
	assign bus_start = scl_sync_ff & scl_prev_ff & sda_prev_ff & ~sda_sync_ff;
	assign bus_stop = scl_sync_ff & scl_prev_ff & ~sda_prev_ff & sda_sync_ff;

	// ------------------------------------------------------------
	// register storage and slave state
	// ------------------------------------------------------------
	ccr_pkg::ccr_pwr_path_t pwr_ff, nxt_pwr;
	ccr_pkg::ccr_dplus_tmr_t tmr_ff, nxt_tmr;
	ccr_pkg::ccr_icl_t icl_ff, nxt_icl;
	logic released_ff, nxt_released;
	ccr_pkg::ccr_state_t state_ff, nxt_state;
	ccr_pkg::ccr_state_t after_ff, nxt_after;
	logic [7:0] shift_ff, nxt_shift;
	logic [7:0] ptr_ff, nxt_ptr;
	logic [2:0] cnt_ff, nxt_cnt;
	logic full_ff, nxt_full;
	logic nack_ff, nxt_nack;
	logic sda_oe_n_ff, nxt_sda_oe_n;

	// read view; reserved bits show their reset values
	function automatic logic [7:0] rd_byte(input logic [7:0] ofs,
			input ccr_pkg::ccr_pwr_path_t p, input ccr_pkg::ccr_dplus_tmr_t t,
			input ccr_pkg::ccr_icl_t c, input logic rel);
		ccr_pkg::ccr_pwr_path_t pv;
		ccr_pkg::ccr_dplus_tmr_t tv;
		ccr_pkg::ccr_icl_t cv;
		pv = p;
		tv = t;
		cv = c;
		pv.rsvd = ccr_pkg::RST_PWR_PATH[7];
		// release bit is a strobe and never reads back
		tv.release_dplus_source = 1'b0;
		// state bit reflects the source
		tv.dplus_source_state = rel;
		cv.rsvd = ccr_pkg::RST_ICL[2:0];
		unique case (ofs)
			ccr_pkg::OFS_PWR_PATH: rd_byte = pv;
			ccr_pkg::OFS_DPLUS_TMR: rd_byte = tv;
			ccr_pkg::OFS_ICL: rd_byte = cv;
			default: rd_byte = ccr_pkg::UNMAPPED_READ;
		endcase
	endfunction

	always_comb begin
		ccr_pkg::ccr_dplus_tmr_t wt;
		wt = shift_ff;
		nxt_pwr = pwr_ff;
		nxt_tmr = tmr_ff;
		nxt_icl = icl_ff;
		nxt_released = released_ff;
		nxt_state = state_ff;
		nxt_after = after_ff;
		nxt_shift = shift_ff;
		nxt_ptr = ptr_ff;
		nxt_cnt = cnt_ff;
		nxt_full = full_ff;
		nxt_nack = nack_ff;
		nxt_sda_oe_n = sda_oe_n_ff;
		// external re-arm puts the source back on
		if (i_dplus_source_arm) begin
			nxt_released = 1'b0;
		end
		if (bus_start) begin
			nxt_state = ccr_pkg::ST_ADDR;
			nxt_cnt = 3'h0;
			nxt_full = 1'b0;
			nxt_sda_oe_n = 1'b1;
		end else if (bus_stop) begin
			nxt_state = ccr_pkg::ST_IDLE;
			nxt_sda_oe_n = 1'b1;
		end else begin
			unique case (state_ff)
				ccr_pkg::ST_IDLE: begin
					nxt_sda_oe_n = 1'b1;
				end
				ccr_pkg::ST_ADDR, ccr_pkg::ST_REG, ccr_pkg::ST_WR: begin
					if (scl_rise) begin
						nxt_shift = {shift_ff[6:0], sda_sync_ff};
						nxt_cnt = 3'(cnt_ff + 3'h1);
						nxt_full = (cnt_ff == ccr_pkg::BIT_LAST);
					end else if (scl_fall && full_ff) begin
						nxt_full = 1'b0;
						nxt_state = ccr_pkg::ST_ACK;
						nxt_sda_oe_n = 1'b0;
						if (state_ff == ccr_pkg::ST_ADDR) begin
							nxt_after = shift_ff[0] ? ccr_pkg::ST_RD : ccr_pkg::ST_REG;
							if (shift_ff[7:1] != BUS_ADDR) begin
								nxt_state = ccr_pkg::ST_IDLE;
								nxt_sda_oe_n = 1'b1;
							end
						end else if (state_ff == ccr_pkg::ST_REG) begin
							nxt_ptr = shift_ff;
							nxt_after = ccr_pkg::ST_WR;
						end else begin
							nxt_after = ccr_pkg::ST_WR;
							nxt_ptr = 8'(ptr_ff + 8'h01);
							unique case (ptr_ff)
								ccr_pkg::OFS_PWR_PATH: begin
									nxt_pwr = shift_ff;
									nxt_pwr.rsvd = ccr_pkg::RST_PWR_PATH[7];
								end
								ccr_pkg::OFS_DPLUS_TMR: begin
									nxt_tmr.fast_charge_timeout = wt.fast_charge_timeout;
									nxt_tmr.precharge_timeout = wt.precharge_timeout;
									nxt_tmr.charge_timer_hold = wt.charge_timer_hold;
									if (wt.release_dplus_source) begin
										nxt_released = 1'b1;
									end
								end
								ccr_pkg::OFS_ICL: begin
									nxt_icl.input_current_limit = shift_ff[7:3];
								end
								default: begin
								end
							endcase
						end
					end
				end
				ccr_pkg::ST_ACK: begin
					if (scl_fall) begin
						nxt_state = after_ff;
						nxt_cnt = 3'h0;
						nxt_sda_oe_n = 1'b1;
						if (after_ff == ccr_pkg::ST_RD) begin
							nxt_shift = rd_byte(ptr_ff, pwr_ff, tmr_ff, icl_ff, released_ff);
							nxt_sda_oe_n = nxt_shift[7];
						end
					end
				end
				ccr_pkg::ST_RD: begin
					if (scl_rise) begin
						nxt_cnt = 3'(cnt_ff + 3'h1);
						nxt_full = (cnt_ff == ccr_pkg::BIT_LAST);
					end else if (scl_fall) begin
						if (full_ff) begin
							nxt_full = 1'b0;
							nxt_state = ccr_pkg::ST_MACK;
							nxt_ptr = 8'(ptr_ff + 8'h01);
							nxt_sda_oe_n = 1'b1;
						end else begin
							nxt_shift = {shift_ff[6:0], 1'b0};
							nxt_sda_oe_n = shift_ff[6];
						end
					end
				end
				ccr_pkg::ST_MACK: begin
					if (scl_rise) begin
						nxt_nack = sda_sync_ff;
					end else if (scl_fall) begin
						nxt_cnt = 3'h0;
						if (nack_ff) begin
							nxt_state = ccr_pkg::ST_IDLE;
						end else begin
							nxt_state = ccr_pkg::ST_RD;
							nxt_shift = rd_byte(ptr_ff, pwr_ff, tmr_ff, icl_ff, released_ff);
							nxt_sda_oe_n = nxt_shift[7];
						end
					end
				end
				default: begin
					nxt_state = ccr_pkg::ST_IDLE;
				end
			endcase
		end
	end

	// ------------------------------------------------------------
	// decoded controls
	// ------------------------------------------------------------
	logic nxt_pull_up, nxt_pull_down, nxt_vreg_en, nxt_icl_en;
	logic [13:0] nxt_mv;
	logic [4:0] nxt_fc_hrs;
	logic [5:0] nxt_prc_min;
	logic [11:0] nxt_ma;
	logic pull_up_ff, pull_down_ff, vreg_en_ff, icl_en_ff, hold_ff, dp_on_ff;
	logic [13:0] mv_ff;
	logic [4:0] fc_hrs_ff;
	logic [5:0] prc_min_ff;
	logic [11:0] ma_ff;

	always_comb begin
		logic low;
		low = 1'b0;
		if (pwr_ff.pin_control_source_select) begin
			low = i_hw_powerpath_pull_low;
		end else begin
			low = pwr_ff.powerpath_pin_level;
		end
		// zero pulls up, one pulls down
		nxt_pull_up = ~low;
		nxt_pull_down = low;
		nxt_vreg_en = ~pwr_ff.input_voltage_reg_disable;
		nxt_mv = volt_mv(pwr_ff.input_voltage_reg_level);
		// fast charge hours, undefined code saturates
		if (tmr_ff.fast_charge_timeout > ccr_pkg::FC_LAST_CODE) begin
			nxt_fc_hrs = 5'(ccr_pkg::FC_BASE_HRS + {2'h0, ccr_pkg::FC_LAST_CODE} * ccr_pkg::FC_STEP_HRS);
		end else begin
			nxt_fc_hrs = 5'(ccr_pkg::FC_BASE_HRS + {2'h0, tmr_ff.fast_charge_timeout} * ccr_pkg::FC_STEP_HRS);
		end
		if (tmr_ff.precharge_timeout > ccr_pkg::PRC_LAST_CODE) begin
			nxt_prc_min = 6'(ccr_pkg::PRC_BASE_MIN + {4'h0, ccr_pkg::PRC_LAST_CODE} * ccr_pkg::PRC_STEP_MIN);
		end else begin
			nxt_prc_min = 6'(ccr_pkg::PRC_BASE_MIN + {4'h0, tmr_ff.precharge_timeout} * ccr_pkg::PRC_STEP_MIN);
		end
		nxt_ma = icl_ma(icl_ff.input_current_limit);
		nxt_icl_en = (icl_ff.input_current_limit != ccr_pkg::ICL_CODE_OFF);
	end

	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			pwr_ff <= ccr_pkg::RST_PWR_PATH;
			tmr_ff <= ccr_pkg::RST_DPLUS_TMR;
			icl_ff <= ccr_pkg::RST_ICL;
			released_ff <= ccr_pkg::RST_DPLUS_TMR[6];
			state_ff <= ccr_pkg::ST_IDLE;
			after_ff <= ccr_pkg::ST_IDLE;
			shift_ff <= 8'h00;
			ptr_ff <= 8'h00;
			cnt_ff <= 3'h0;
			full_ff <= 1'b0;
			nack_ff <= 1'b0;
			sda_oe_n_ff <= 1'b1;
			pull_up_ff <= 1'b0;
			pull_down_ff <= 1'b0;
			vreg_en_ff <= 1'b0;
			mv_ff <= 14'h0000;
			fc_hrs_ff <= 5'h00;
			prc_min_ff <= 6'h00;
			hold_ff <= 1'b0;
			icl_en_ff <= 1'b0;
			ma_ff <= 12'h000;
			dp_on_ff <= 1'b0;
		end else begin
			pwr_ff <= nxt_pwr;
			tmr_ff <= nxt_tmr;
			icl_ff <= nxt_icl;
			released_ff <= nxt_released;
			state_ff <= nxt_state;
			after_ff <= nxt_after;
			shift_ff <= nxt_shift;
			ptr_ff <= nxt_ptr;
			cnt_ff <= nxt_cnt;
			full_ff <= nxt_full;
			nack_ff <= nxt_nack;
			sda_oe_n_ff <= nxt_sda_oe_n;
			pull_up_ff <= nxt_pull_up;
			pull_down_ff <= nxt_pull_down;
			vreg_en_ff <= nxt_vreg_en;
			mv_ff <= nxt_mv;
			fc_hrs_ff <= nxt_fc_hrs;
			prc_min_ff <= nxt_prc_min;
			hold_ff <= tmr_ff.charge_timer_hold;
			icl_en_ff <= nxt_icl_en;
			ma_ff <= nxt_ma;
			dp_on_ff <= ~released_ff;
		end
	end

	// open drain: line only ever pulled low
	assign o_sda_out = 1'b0;
	assign o_sda_oe_n = sda_oe_n_ff;
	assign o_powerpath_pull_up = pull_up_ff;
	assign o_powerpath_pull_down = pull_down_ff;
	assign o_min_input_voltage_regulation_en = vreg_en_ff;
	assign o_min_input_voltage_mv = mv_ff;
	assign o_dplus_source_on = dp_on_ff;
	assign o_fast_charge_hours = fc_hrs_ff;
	assign o_precharge_minutes = prc_min_ff;
	assign o_charge_timer_hold = hold_ff;
	assign o_average_input_current_regulation_en = icl_en_ff;
	assign o_input_current_limit_ma = ma_ff;

endmodule // ccr_regs

// ### test/ccr_regs_monitor.sv
// port checker for the charger control register bank
`timescale 1ns/1ps

module ccr_regs_monitor (
	input wire logic i_sys_clk,
	input wire logic i_rst_n,
	input wire logic i_scl,
	input wire logic i_sda,
	input wire logic o_sda_out,
	input wire logic o_sda_oe_n,
	input wire logic i_hw_powerpath_pull_low,
	input wire logic i_dplus_source_arm,
	input wire logic o_powerpath_pull_up,
	input wire logic o_powerpath_pull_down,
	input wire logic o_min_input_voltage_regulation_en,
	input wire logic [13:0] o_min_input_voltage_mv,
	input wire logic o_dplus_source_on,
	input wire logic [4:0] o_fast_charge_hours,
	input wire logic [5:0] o_precharge_minutes,
	input wire logic o_charge_timer_hold,
	input wire logic o_average_input_current_regulation_en,
	input wire logic [11:0] o_input_current_limit_ma
);
	default clocking cb @(posedge i_sys_clk);
	endclocking
	default disable iff (!i_rst_n);

	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	// first edge after release still samples reset values, hence the $past guard
	chk_pull_one_way: assert property ($past(i_rst_n) |->
		(o_powerpath_pull_up ^ o_powerpath_pull_down))
		else $error("power-path pin pulled both or neither way");
	chk_mv_legal: assert property ($past(i_rst_n) |-> o_min_input_voltage_mv inside
		{14'h0FA0, 14'h109A, 14'h1194, 14'h128E, 14'h1B58, 14'h1D4C, 14'h1F40, 14'h2134})
		else $error("voltage level outside the eight settings");
	chk_hours_legal: assert property ($past(i_rst_n) |-> o_fast_charge_hours inside
		{5'h04, 5'h06, 5'h08, 5'h0A, 5'h0C, 5'h0E, 5'h10})
		else $error("fast charge hours illegal");
	chk_minutes_legal: assert property ($past(i_rst_n) |->
		o_precharge_minutes inside {6'h1E, 6'h2D, 6'h3C})
		else $error("pre-charge minutes illegal");
	chk_icl_off_zero: assert property (!o_average_input_current_regulation_en
		&& $past(i_rst_n) |-> o_input_current_limit_ma == 12'h000)
		else $error("disabled current limit not zero");
	chk_icl_steps: assert property (o_average_input_current_regulation_en |->
		(o_input_current_limit_ma inside {12'h064, 12'h096}) ||
		(o_input_current_limit_ma >= 12'h1F4 && o_input_current_limit_ma <= 12'hBB8
		&& o_input_current_limit_ma % 12'h064 == 12'h000))
		else $error("current limit off the step grid");
	chk_dplus_rise_cause: assert property ($rose(o_dplus_source_on) && $past(i_rst_n, 2)
		|-> $past(i_dplus_source_arm) || $past(i_dplus_source_arm, 2))
		else $error("D+ source came back without arm");
	chk_dplus_arm_on: assert property (i_dplus_source_arm |-> ##[1:3] o_dplus_source_on)
		else $error("D+ source not back after arm");
	chk_sda_open_drain: assert property (!o_sda_out)
		else $error("data pin driven high");
	// data line may only move while the serial clock is low
	chk_sda_low_phase: assert property ($changed(o_sda_oe_n) |-> !i_scl)
		else $error("data pin changed while serial clock high");
endmodule // ccr_regs_monitor

bind ccr_regs ccr_regs_monitor u_ccr_regs_monitor (
	.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_scl(i_scl), .i_sda(i_sda),
	.o_sda_out(o_sda_out), .o_sda_oe_n(o_sda_oe_n),
	.i_hw_powerpath_pull_low(i_hw_powerpath_pull_low), .i_dplus_source_arm(i_dplus_source_arm),
	.o_powerpath_pull_up(o_powerpath_pull_up), .o_powerpath_pull_down(o_powerpath_pull_down),
	.o_min_input_voltage_regulation_en(o_min_input_voltage_regulation_en),
	.o_min_input_voltage_mv(o_min_input_voltage_mv), .o_dplus_source_on(o_dplus_source_on),
	.o_fast_charge_hours(o_fast_charge_hours), .o_precharge_minutes(o_precharge_minutes),
	.o_charge_timer_hold(o_charge_timer_hold),
	.o_average_input_current_regulation_en(o_average_input_current_regulation_en),
	.o_input_current_limit_ma(o_input_current_limit_ma));

// ### test/ccr_host_model.sv
// two-wire host model driving the charger register bank
`timescale 1ns/1ps

module ccr_host_model #(
	parameter int HALF = 10
) (
	input wire logic i_sys_clk,
	input wire logic i_sda,
	output logic o_scl,
	output logic o_sda
);
	// idle bus: both lines released high
	initial begin
		o_scl = 1'b1;
		o_sda = 1'b1;
	end

	task automatic tick(input int n);
		repeat (n) @(posedge i_sys_clk);
		#1;
	endtask

	// ------------------------------------------------------------
	// bus conditions
	// ------------------------------------------------------------
	// host side framing
	// data moves only mid-low so the synced clock never sees a false start
	task automatic bus_start();
		tick(HALF / 2);
		o_sda = 1'b1;
		tick(HALF / 2);
		o_scl = 1'b1;
		tick(HALF);
		o_sda = 1'b0;
		tick(HALF);
		o_scl = 1'b0;
	endtask

	task automatic bus_stop();
		tick(HALF / 2);
		o_sda = 1'b0;
		tick(HALF / 2);
		o_scl = 1'b1;
		tick(HALF);
		o_sda = 1'b1;
		tick(HALF);
	endtask

	// whole bytes, msb first
	// ninth slot always released: write ack seen, read ended by nack
	task automatic byte_io(input logic [7:0] wb, output logic [7:0] rb, output logic ack);
		for (int i = 8; i >= 0; i--) begin
			tick(HALF / 2);
			o_sda = (i == 0) ? 1'b1 : wb[(i + 7) % 8];
			tick(HALF / 2);
			o_scl = 1'b1;
			tick(HALF / 2);
			if (i == 0) begin
				ack = i_sda;
			end else begin
				rb[i - 1] = i_sda;
			end
			tick(HALF / 2);
			o_scl = 1'b0;
		end
	endtask
endmodule // ccr_host_model

// ### test/tb_top.sv
// self-checking bench for the charger control register bank
`timescale 1ns/1ps

module tb_top;
	localparam logic [7:0] RST_TAB [3] = '{8'h40, 8'h00, 8'h2F};
	localparam logic [4:0] ICL_CODE [14] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h05, 5'h06,
		5'h07, 5'h0A, 5'h0B, 5'h0F, 5'h14, 5'h1E, 5'h1F};
	localparam logic [11:0] ICL_MA [14] = '{12'h064, 12'h064, 12'h096, 12'h096, 12'h1F4,
		12'h1F4, 12'h258, 12'h2BC, 12'h3E8, 12'h44C, 12'h5DC, 12'h7D0, 12'hBB8, 12'h000};
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic hw = 1'b0;
	logic arm = 1'b0;
	logic scl, host_sda, sda_out, sda_oe_n, pull_up, pull_dn, vreg_en, dp_on, hold, icl_en;
	logic [13:0] mv;
	logic [4:0] hours;
	logic [5:0] mins;
	logic [11:0] ma;
	logic [7:0] d;
	int n_errors = 0;
	int compares = 0;
	wire sda_wire;

	// pulled-up data line, low when either side pulls
	assign sda_wire = host_sda & (sda_oe_n | sda_out);
	always #2 clk = ~clk;

	ccr_host_model u_ccr_host_model (.i_sys_clk(clk), .i_sda(sda_wire), .o_scl(scl),
		.o_sda(host_sda));
	ccr_regs u_ccr_regs (.i_sys_clk(clk), .i_rst_n(rst_n), .i_scl(scl), .i_sda(sda_wire),
		.o_sda_out(sda_out), .o_sda_oe_n(sda_oe_n), .i_hw_powerpath_pull_low(hw),
		.i_dplus_source_arm(arm), .o_powerpath_pull_up(pull_up), .o_powerpath_pull_down(pull_dn),
		.o_min_input_voltage_regulation_en(vreg_en), .o_min_input_voltage_mv(mv),
		.o_dplus_source_on(dp_on), .o_fast_charge_hours(hours), .o_precharge_minutes(mins),
		.o_charge_timer_hold(hold), .o_average_input_current_regulation_en(icl_en),
		.o_input_current_limit_ma(ma));

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		compares++;
		if (seen !== exp) begin
			n_errors++;
			$display("[ERR] %0t mismatch seen %0h expected %0h", $time, seen, exp);
		end
	endtask

	task automatic test_done();
		$display("errors %0d compares %0d", n_errors, compares);
		if (n_errors == 0 && compares > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	task automatic reg_write(input logic [7:0] ofs, input logic [7:0] wd);
		logic [7:0] r;
		logic a0, a1, a2;
		u_ccr_host_model.bus_start();
		u_ccr_host_model.byte_io({ccr_pkg::DEF_BUS_ADDR, 1'b0}, r, a0);
		u_ccr_host_model.byte_io(ofs, r, a1);
		u_ccr_host_model.byte_io(wd, r, a2);
		u_ccr_host_model.bus_stop();
		check(16'({a0, a1, a2}), 16'h0000);
		tick(6);
	endtask

	task automatic rd_check(input logic [7:0] ofs, input logic [7:0] exp);
		logic [7:0] r;
		logic a0, a1, a2, a3;
		u_ccr_host_model.bus_start();
		u_ccr_host_model.byte_io({ccr_pkg::DEF_BUS_ADDR, 1'b0}, r, a0);
		u_ccr_host_model.byte_io(ofs, r, a1);
		u_ccr_host_model.bus_start();
		u_ccr_host_model.byte_io({ccr_pkg::DEF_BUS_ADDR, 1'b1}, r, a2);
		u_ccr_host_model.byte_io(8'hFF, r, a3);
		u_ccr_host_model.bus_stop();
		check(16'({a0, a1, a2}), 16'h0000);
		check(16'(r), 16'(exp));
	endtask

	// ------------------------------------------------------------
	// tests
	// ------------------------------------------------------------
	initial begin
		tick(2);
		rst_n = 1'b1;
		tick(8);
		check(16'(mv), 16'h0FA0);
		check(16'({hours, mins}), 16'({5'h04, 6'h1E}));
		check(16'({ma, icl_en, vreg_en, dp_on}), 16'({12'h1F4, 3'h7}));
		check(16'({pull_up, pull_dn}), 16'h0002);
		for (int i = 0; i < 3; i++) begin
			rd_check(8'h21 + 8'(i), RST_TAB[i]);
		end
		// hw follow, level ignored, then software pull both ways
		// hardware owns the pin for the first two, software level 1 then 0 for the last two
		for (int i = 0; i < 4; i++) begin
			hw = (i == 0 || i == 3);
			reg_write(8'h21, (i < 2) ? (8'h40 | 8'(i == 1) << 5) : 8'(i == 2) << 5);
			check(16'(pull_up), 16'(4'b1010 >> i & 4'h1));
			check(16'(pull_dn), 16'(~(4'b1010 >> i) & 4'h1));
		end
		for (int c = 0; c < 8; c++) begin
			d = {3'b010, c[0], 4'(c)};
			reg_write(8'h21, d);
			check(16'(mv), (c < 4) ? 16'h0FA0 + 16'(c) * 16'h00FA
				: 16'h1B58 + 16'(c - 4) * 16'h01F4);
			check(16'(vreg_en), 16'(!c[0]));
			rd_check(8'h21, d);
		end
		for (int i = 0; i < 7; i++) begin
			d = {2'b00, 3'(i), 2'(i % 3), i[0]};
			reg_write(8'h22, d);
			check(16'(hours), 16'h0004 + 16'(i) * 16'h0002);
			check(16'(mins), 16'h001E + 16'(i % 3) * 16'h000F);
			check(16'({hold, dp_on}), 16'({i[0], 1'b1}));
			rd_check(8'h22, d);
		end
		reg_write(8'h22, 8'h80);
		check(16'(dp_on), 16'h0000);
		rd_check(8'h22, 8'h40);
		reg_write(8'h22, 8'h00);
		check(16'(dp_on), 16'h0000);
		arm = 1'b1;
		tick(1);
		arm = 1'b0;
		tick(4);
		check(16'(dp_on), 16'h0001);
		reg_write(8'h22, 8'h40);
		rd_check(8'h22, 8'h00);
		// defined codes only, reserved bits at reset value
		for (int i = 0; i < 14; i++) begin
			reg_write(8'h23, {ICL_CODE[i], 3'b111});
			check(16'(ma), 16'(ICL_MA[i]));
			check(16'(icl_en), 16'(ICL_CODE[i] != 5'h1F));
		end
		rd_check(8'h23, 8'hFF);
		reg_write(8'h30, 8'hFF);
		rd_check(8'h30, 8'h00);
		test_done();
	end

	// whole run needs about 40000 clocks
	initial begin
		tick(90000);
		n_errors++;
		test_done();
	end
endmodule // tb_top
